// ### design/psi_pkg.sv
/*
 * Shared constants and types for the program counter, return stack and
 * indirect addressing unit: register offsets, reset values, memory map
 * bounds, operation codes and the packed carriers used at the ports.
 * Assumes an APB bus with 32-bit data and byte addresses, one word per register.
 */
package psi_pkg;

    localparam int PSI_PC_W = 15;
    localparam int PSI_SP_W = 5;
    localparam int PSI_STACK_DEPTH = 16;
    localparam logic [4:0] PSI_SP_RESET = 5'h1f;
    localparam logic [4:0] PSI_SP_FULL = 5'h0f;
    localparam logic [4:0] PSI_SP_EMPTY = 5'h1f;
    localparam logic [14:0] PSI_VECTOR_ADDR = 15'h0004;

    // Register byte offsets
    localparam logic [7:0] PSI_OFF_PC_LOW = 8'h00;
    localparam logic [7:0] PSI_OFF_PC_LATCH = 8'h04;
    localparam logic [7:0] PSI_OFF_STACK_PTR = 8'h08;
    localparam logic [7:0] PSI_OFF_TOS_LOW = 8'h0c;
    localparam logic [7:0] PSI_OFF_TOS_HIGH = 8'h10;
    localparam logic [7:0] PSI_OFF_FSR0_LOW = 8'h14;
    localparam logic [7:0] PSI_OFF_FSR0_HIGH = 8'h18;
    localparam logic [7:0] PSI_OFF_FSR1_LOW = 8'h1c;
    localparam logic [7:0] PSI_OFF_FSR1_HIGH = 8'h20;
    localparam logic [7:0] PSI_OFF_POWER_CTRL = 8'h24;
    localparam logic [7:0] PSI_OFF_CONFIG = 8'h28;

    localparam int PSI_PWR_OVF_BIT = 0;
    localparam int PSI_PWR_UNF_BIT = 1;
    localparam int PSI_CFG_FAULT_RST_BIT = 0;
    localparam logic PSI_CFG_FAULT_RST_RESET = 1'b1;

    // Indirect address map
    localparam logic [15:0] PSI_TRAD_LAST = 16'h0fff;
    localparam logic [15:0] PSI_LIN_BASE = 16'h2000;
    localparam logic [15:0] PSI_LIN_LAST = 16'h29af;
    localparam logic [12:0] PSI_GPR_BLOCK = 13'h0050;
    localparam logic [11:0] PSI_GPR_FIRST = 12'h020;
    localparam logic [6:0] PSI_INDF_LAST = 7'h01;

    typedef enum logic [2:0] {
        PSI_OP_NONE = 3'h0,
        PSI_OP_NEXT = 3'h1,
        PSI_OP_WRITE_LOW = 3'h2,
        PSI_OP_CALL = 3'h3,
        PSI_OP_COMPUTED_CALL = 3'h4,
        PSI_OP_BRW = 3'h5,
        PSI_OP_BRA = 3'h6,
        PSI_OP_RETURN = 3'h7
    } psi_pc_op_e;

    typedef enum logic [2:0] {
        PSI_RG_TRAD = 3'h0,
        PSI_RG_LIN = 3'h1,
        PSI_RG_PROG = 3'h2,
        PSI_RG_SELF = 3'h3,
        PSI_RG_NONE = 3'h4
    } psi_region_e;

    typedef struct packed {
        psi_pc_op_e kind;
        logic vector;
        logic [10:0] arg;
    } psi_pc_op_s;

    typedef struct packed {
        logic sel;
        logic we;
        logic [7:0] wdata;
    } psi_ind_req_s;

endpackage : psi_pkg

// ### design/psi_stack.sv
/*
 * Return-address stack: sixteen 15-bit entries in flip-flops, a five-bit
 * pointer and software access to the selected entry.
 * Assumes push and pop are never asserted together; the top resolves it.
 */
`timescale 1ns/10ps
`default_nettype none
module psi_stack #(
    parameter int DEPTH = psi_pkg::PSI_STACK_DEPTH,
    parameter int WIDTH = psi_pkg::PSI_PC_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_value,
    input wire logic ptr_we,
    input wire logic [psi_pkg::PSI_SP_W-1:0] ptr_wdata,
    input wire logic tos_lo_we,
    input wire logic tos_hi_we,
    input wire logic [7:0] tos_wdata,
    output logic [psi_pkg::PSI_SP_W-1:0] ptr,
    output logic [WIDTH-1:0] tos
);
    import psi_pkg::*;

    // The pointer's spare top bit is what makes wrap detection possible
    initial
    begin
        if (DEPTH != 2 ** (PSI_SP_W - 1) || WIDTH <= 8 || WIDTH > 16)
        begin
            $error("psi_stack: unsupported depth or width");
        end
    end

    localparam int IW = $clog2(DEPTH);

    logic [PSI_SP_W-1:0] ptr_r;
    logic [PSI_SP_W-1:0] ptr_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    wire [PSI_SP_W-1:0] ptr_inc = ptr_r + 5'h01;
    wire [IW-1:0] wr_idx = push ? ptr_inc[IW-1:0] : ptr_r[IW-1:0];
    wire sw_access = !push && !pop;

    // Pointer: push increments before the store, pop decrements after read
    assign ptr_nxt = clear ? PSI_SP_RESET :
                     push ? ptr_inc :
                     pop ? ptr_r - 5'h01 :
                     ptr_we ? ptr_wdata : ptr_r;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ptr_r <= PSI_SP_RESET;
        else
            ptr_r <= ptr_nxt;
    end

    // Entries only wrap on the low index bits, so push 17 lands on entry 0
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        wire hit = (wr_idx == IW'(i));
        wire [WIDTH-1:0] sw_val = {tos_hi_we ? tos_wdata[WIDTH-9:0] : mem_r[i][WIDTH-1:8],
                                   tos_lo_we ? tos_wdata : mem_r[i][7:0]};
        always_ff @(posedge ref_clk)
        begin
            if (push && hit)
                mem_r[i] <= push_value;
            else if (sw_access && hit && (tos_lo_we || tos_hi_we))
                mem_r[i] <= sw_val;
        end
    end

    assign ptr = ptr_r;
    assign tos = mem_r[ptr_r[IW-1:0]];

endmodule : psi_stack
`default_nettype wire

// ### design/psi_fsr_map.sv
/*
 * Indirect address decoder: classifies a 16-bit file select pointer and
 * turns it into a data memory or program memory address.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/10ps
`default_nettype none
module psi_fsr_map (
    input wire logic [15:0] fsr,
    output psi_pkg::psi_region_e region,
    output logic [11:0] data_addr,
    output logic [14:0] prog_addr
);
    import psi_pkg::*;

    // Linear window: divide by the block size, a constant divider is cheap
    wire [12:0] lin_off = 13'(fsr - PSI_LIN_BASE);
    wire [12:0] lin_bank = lin_off / PSI_GPR_BLOCK;
    wire [12:0] lin_idx = lin_off % PSI_GPR_BLOCK;
    wire [11:0] lin_addr = {lin_bank[4:0], 7'h00} + PSI_GPR_FIRST + {5'h00, lin_idx[6:0]};

    wire is_prog = fsr[15];
    wire is_trad = fsr <= PSI_TRAD_LAST;
    wire is_lin = fsr >= PSI_LIN_BASE && fsr <= PSI_LIN_LAST;
    wire is_self = is_trad && fsr[6:0] <= PSI_INDF_LAST;

    // Region priority: program, self, traditional, linear, else unimplemented
    assign region = is_prog ? PSI_RG_PROG :
                    is_self ? PSI_RG_SELF :
                    is_trad ? PSI_RG_TRAD :
                    is_lin ? PSI_RG_LIN : PSI_RG_NONE;
    assign data_addr = is_lin ? lin_addr : fsr[11:0];
    assign prog_addr = fsr[14:0];

endmodule : psi_fsr_map
`default_nettype wire

// ### design/psi_top.sv
/*
 * Program counter, return stack and indirect addressing unit of the core.
 * Holds the program counter and its high latch, drives the return stack,
 * keeps the two file select pointers and sequences indirect accesses.
 * Assumes execution logic presents one pc operation per cycle and a data
 * and program memory that answer combinationally to the read strobes.
 */
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module psi_top #(
    parameter logic [14:0] VECTOR_ADDR = psi_pkg::PSI_VECTOR_ADDR
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire psi_pkg::psi_pc_op_s pc_op,
    input wire logic [7:0] w_value,
    input wire logic ind_req,
    input wire psi_pkg::psi_ind_req_s ind_cmd,
    input wire logic [7:0] dmem_rdata,
    input wire logic [13:0] pmem_rdata,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata_r,
    output logic pready_r,
    output logic pslverr_r,
    output logic [14:0] pc_r,
    output logic fault_reset_r,
    output logic ind_busy_r,
    output logic ind_done_r,
    output logic [7:0] ind_rdata_r,
    output logic [11:0] dmem_addr_r,
    output logic dmem_rd_r,
    output logic dmem_wr_r,
    output logic [7:0] dmem_wdata_r,
    output logic [14:0] pmem_addr_r,
    output logic pmem_rd_r
);
    import psi_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_PROG = 3'b100
    } psi_ind_state_e;

    // Address decode shared by the write and error paths; the read mux compares offsets itself
    function automatic logic psi_reg_hit(input logic [7:0] addr);
        psi_reg_hit = addr == PSI_OFF_PC_LOW || addr == PSI_OFF_PC_LATCH ||
                      addr == PSI_OFF_STACK_PTR || addr == PSI_OFF_TOS_LOW ||
                      addr == PSI_OFF_TOS_HIGH || addr == PSI_OFF_FSR0_LOW ||
                      addr == PSI_OFF_FSR0_HIGH || addr == PSI_OFF_FSR1_LOW ||
                      addr == PSI_OFF_FSR1_HIGH || addr == PSI_OFF_POWER_CTRL ||
                      addr == PSI_OFF_CONFIG;
    endfunction : psi_reg_hit

    logic [6:0] pc_latch_r;
    logic [7:0] fsr0_low_r;
    logic [7:0] fsr0_high_r;
    logic [7:0] fsr1_low_r;
    logic [7:0] fsr1_high_r;
    logic ovf_flag_r;
    logic unf_flag_r;
    logic cfg_fault_rst_r;
    logic [14:0] pc_nxt;
    psi_ind_state_e state_r;
    psi_ind_state_e state_nxt;
    logic [PSI_SP_W-1:0] stack_ptr;
    logic [14:0] stack_tos;
    psi_region_e map_region;
    logic [11:0] map_data_addr;
    logic [14:0] map_prog_addr;
    psi_region_e cur_region_r;
    logic cur_we_r;

    // APB strobes: writes land in the access phase, reads are sampled in setup
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite && pstrb[0] && psi_reg_hit(paddr);
    wire [7:0] wbyte = pwdata[7:0];
    wire wr_pc_low = apb_wr && paddr == PSI_OFF_PC_LOW;
    wire wr_pc_latch = apb_wr && paddr == PSI_OFF_PC_LATCH;
    wire wr_sp = apb_wr && paddr == PSI_OFF_STACK_PTR;
    wire wr_tos_low = apb_wr && paddr == PSI_OFF_TOS_LOW;
    wire wr_tos_high = apb_wr && paddr == PSI_OFF_TOS_HIGH;
    wire wr_fsr0_low = apb_wr && paddr == PSI_OFF_FSR0_LOW;
    wire wr_fsr0_high = apb_wr && paddr == PSI_OFF_FSR0_HIGH;
    wire wr_fsr1_low = apb_wr && paddr == PSI_OFF_FSR1_LOW;
    wire wr_fsr1_high = apb_wr && paddr == PSI_OFF_FSR1_HIGH;
    wire wr_power = apb_wr && paddr == PSI_OFF_POWER_CTRL;
    wire wr_config = apb_wr && paddr == PSI_OFF_CONFIG;

    // Stack operations decoded from the pc operation
    wire op_call = pc_op.kind == PSI_OP_CALL || pc_op.kind == PSI_OP_COMPUTED_CALL;
    wire do_push = !fault_reset_r && (op_call || pc_op.vector);
    wire do_pop = !fault_reset_r && !pc_op.vector && pc_op.kind == PSI_OP_RETURN;
    wire stk_overflow = do_push && stack_ptr == PSI_SP_FULL;
    wire stk_underflow = do_pop && stack_ptr == PSI_SP_EMPTY;
    wire [14:0] pc_inc = pc_r + 15'h0001;
    wire [14:0] bra_off = {{6{pc_op.arg[8]}}, pc_op.arg[8:0]};
    // A vector saves the interrupted instruction; calls save the one after
    wire [14:0] push_value = pc_op.vector ? pc_r : pc_inc;

    // Program counter source selection
    always_comb
    begin
        pc_nxt = pc_r;
        unique case (pc_op.kind)
            PSI_OP_NONE: pc_nxt = wr_pc_low ? {pc_latch_r, wbyte} : pc_r;
            PSI_OP_NEXT: pc_nxt = pc_inc;
            PSI_OP_WRITE_LOW: pc_nxt = {pc_latch_r, pc_op.arg[7:0]};
            PSI_OP_CALL: pc_nxt = {pc_latch_r[6:3], pc_op.arg[10:0]};
            PSI_OP_COMPUTED_CALL: pc_nxt = {pc_latch_r, w_value};
            PSI_OP_BRW: pc_nxt = pc_inc + {7'h00, w_value};
            PSI_OP_BRA: pc_nxt = pc_inc + bra_off;
            PSI_OP_RETURN: pc_nxt = stack_tos;
        endcase
        if (pc_op.vector)
            pc_nxt = VECTOR_ADDR;
    end

    // Either reset source clears the counter; a fault reset wins over any op
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || fault_reset_r)
            pc_r <= 15'h0000;
        else
            pc_r <= pc_nxt;
    end

    // High latch is software-only; stack traffic never writes it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            pc_latch_r <= 7'h00;
        else if (wr_pc_latch)
            pc_latch_r <= wbyte[6:0];
    end

    // Fault reset fires one cycle after the offending push or pop
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            fault_reset_r <= 1'b0;
        else
            fault_reset_r <= cfg_fault_rst_r && (stk_overflow || stk_underflow);
    end

    // Flags survive the fault reset; a set in the clearing cycle wins
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ovf_flag_r <= 1'b0;
            unf_flag_r <= 1'b0;
        end
        else
        begin
            ovf_flag_r <= stk_overflow || (ovf_flag_r && !(wr_power && !wbyte[PSI_PWR_OVF_BIT]));
            unf_flag_r <= stk_underflow || (unf_flag_r && !(wr_power && !wbyte[PSI_PWR_UNF_BIT]));
        end
    end

    // Configuration: fault reset enable, erased state is enabled
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cfg_fault_rst_r <= PSI_CFG_FAULT_RST_RESET;
        else if (wr_config)
            cfg_fault_rst_r <= wbyte[PSI_CFG_FAULT_RST_BIT];
    end

    // File select pointer bytes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            fsr0_low_r <= 8'h00;
            fsr0_high_r <= 8'h00;
            fsr1_low_r <= 8'h00;
            fsr1_high_r <= 8'h00;
        end
        else
        begin
            if (wr_fsr0_low)
                fsr0_low_r <= wbyte;
            if (wr_fsr0_high)
                fsr0_high_r <= wbyte;
            if (wr_fsr1_low)
                fsr1_low_r <= wbyte;
            if (wr_fsr1_high)
                fsr1_high_r <= wbyte;
        end
    end

    // Return stack; software access yields to pushes and pops in the same cycle
    psi_stack #(
        .DEPTH(PSI_STACK_DEPTH),
        .WIDTH(PSI_PC_W)
    ) u_stack (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(fault_reset_r),
        .push(do_push),
        .pop(do_pop),
        .push_value(push_value),
        .ptr_we(wr_sp),
        .ptr_wdata(wbyte[4:0]),
        .tos_lo_we(wr_tos_low),
        .tos_hi_we(wr_tos_high),
        .tos_wdata(wbyte),
        .ptr(stack_ptr),
        .tos(stack_tos)
    );

    // Indirect address decode of the selected pointer
    wire [15:0] fsr0 = {fsr0_high_r, fsr0_low_r};
    wire [15:0] fsr1 = {fsr1_high_r, fsr1_low_r};

    psi_fsr_map u_map (
        .fsr(ind_cmd.sel ? fsr1 : fsr0),
        .region(map_region),
        .data_addr(map_data_addr),
        .prog_addr(map_prog_addr)
    );

    // Requests arriving while an access is running are ignored
    wire ind_take = ind_req && state_r == ST_IDLE;
    wire map_data = map_region == PSI_RG_TRAD || map_region == PSI_RG_LIN;
    wire map_prog_rd = map_region == PSI_RG_PROG && !ind_cmd.we;

    // Access sequencer: program reads hold one extra cycle
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: state_nxt = ind_take ? ST_ACCESS : ST_IDLE;
            ST_ACCESS: state_nxt = pmem_rd_r ? ST_PROG : ST_IDLE;
            ST_PROG: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Memory strobes; self, unimplemented and program writes drive none
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dmem_rd_r <= 1'b0;
            dmem_wr_r <= 1'b0;
            pmem_rd_r <= 1'b0;
            dmem_addr_r <= 12'h000;
            pmem_addr_r <= 15'h0000;
            dmem_wdata_r <= 8'h00;
            cur_region_r <= PSI_RG_NONE;
            cur_we_r <= 1'b0;
        end
        else if (ind_take)
        begin
            dmem_rd_r <= map_data && !ind_cmd.we;
            dmem_wr_r <= map_data && ind_cmd.we;
            pmem_rd_r <= map_prog_rd;
            dmem_addr_r <= map_data_addr;
            pmem_addr_r <= map_prog_addr;
            dmem_wdata_r <= ind_cmd.wdata;
            cur_region_r <= map_region;
            cur_we_r <= ind_cmd.we;
        end
        else if (state_r == ST_ACCESS)
        begin
            dmem_rd_r <= 1'b0;
            dmem_wr_r <= 1'b0;
        end
        else if (state_r == ST_PROG)
            pmem_rd_r <= 1'b0;
    end

    // Read result: only data regions and program reads carry a value
    wire data_done = state_r == ST_ACCESS && !pmem_rd_r;
    wire prog_done = state_r == ST_PROG;
    wire data_ok = dmem_rd_r && !cur_we_r && cur_region_r != PSI_RG_SELF;
    wire [7:0] data_result = data_ok ? dmem_rdata : 8'h00;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ind_done_r <= 1'b0;
            ind_rdata_r <= 8'h00;
        end
        else
        begin
            ind_done_r <= data_done || prog_done;
            if (prog_done)
                ind_rdata_r <= pmem_rdata[7:0];
            else if (data_done)
                ind_rdata_r <= data_result;
        end
    end

    // Busy covers the access up to the done cycle; it has dropped when done rises
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ind_busy_r <= 1'b0;
        else
            ind_busy_r <= state_nxt != ST_IDLE;
    end

    // Register read mux; unused upper bits read as zero
    wire [7:0] rd_byte =
        paddr == PSI_OFF_PC_LOW ? pc_r[7:0] :
        paddr == PSI_OFF_PC_LATCH ? {1'b0, pc_latch_r} :
        paddr == PSI_OFF_STACK_PTR ? {3'h0, stack_ptr} :
        paddr == PSI_OFF_TOS_LOW ? stack_tos[7:0] :
        paddr == PSI_OFF_TOS_HIGH ? {1'b0, stack_tos[14:8]} :
        paddr == PSI_OFF_FSR0_LOW ? fsr0_low_r :
        paddr == PSI_OFF_FSR0_HIGH ? fsr0_high_r :
        paddr == PSI_OFF_FSR1_LOW ? fsr1_low_r :
        paddr == PSI_OFF_FSR1_HIGH ? fsr1_high_r :
        paddr == PSI_OFF_POWER_CTRL ? {6'h00, unf_flag_r, ovf_flag_r} :
        paddr == PSI_OFF_CONFIG ? {7'h00, cfg_fault_rst_r} : 8'h00;

    // Answers are prepared in setup so every access completes in one cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end
        else
        begin
            pready_r <= apb_setup;
            if (apb_setup)
            begin
                prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                pslverr_r <= !psi_reg_hit(paddr);
            end
            else
                pslverr_r <= 1'b0;
        end
    end

endmodule : psi_top
`default_nettype wire

// ### tb/psi_chk.sv
/* Assertion checker for psi_top, bound from the bench.
   Sees only top-level ports; one clock, synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module psi_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire psi_pkg::psi_pc_op_s pc_op,
    input wire logic [7:0] w_value,
    input wire logic ind_req,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready_r,
    input wire logic [14:0] pc_r,
    input wire logic fault_reset_r,
    input wire logic ind_busy_r,
    input wire logic ind_done_r,
    input wire logic dmem_rd_r,
    input wire logic pmem_rd_r
);
    import psi_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // An op only counts when no vector or fault reset overrides it
    wire logic go = !pc_op.vector && !fault_reset_r;
    wire logic [14:0] bra_t = pc_r + 15'h1 + {{6{pc_op.arg[8]}}, pc_op.arg[8:0]};
    wire logic [14:0] brw_t = pc_r + 15'h1 + {7'h0, w_value};
    chk_pc_step: assert property (go && pc_op.kind == PSI_OP_NEXT
        |=> pc_r == $past(pc_r) + 15'h1) else $error("pc step wrong");
    chk_bra_target: assert property (go && pc_op.kind == PSI_OP_BRA
        |=> pc_r == $past(bra_t)) else $error("literal branch wrong");
    chk_brw_target: assert property (go && pc_op.kind == PSI_OP_BRW
        |=> pc_r == $past(brw_t)) else $error("register branch wrong");
    chk_call_low: assert property (go && pc_op.kind == PSI_OP_CALL
        |=> pc_r[10:0] == $past(pc_op.arg)) else $error("call target wrong");
    chk_computed_call_low: assert property (go && pc_op.kind == PSI_OP_COMPUTED_CALL
        |=> pc_r[7:0] == $past(w_value)) else $error("computed call wrong");
    chk_fault_clear: assert property (fault_reset_r |=> pc_r == 15'h0)
        else $error("pc not cleared");
    chk_ind_answer: assert property (ind_req && !ind_busy_r
        |=> ind_busy_r ##[1:2] ind_done_r) else $error("indirect answer late");
    chk_prog_extra: assert property ($rose(pmem_rd_r)
        |=> pmem_rd_r ##1 (!pmem_rd_r && ind_done_r)) else $error("program read timing");
    chk_data_pulse: assert property (dmem_rd_r |=> !dmem_rd_r && ind_done_r)
        else $error("data read timing");
    chk_apb_ready: assert property (psel && !penable |=> pready_r) else $error("no ready");
    cov_fault: cover property (fault_reset_r);
    cov_prog: cover property ($rose(pmem_rd_r));
    cov_ret: cover property (go && pc_op.kind == PSI_OP_RETURN);
endmodule : psi_chk
`default_nettype wire

// ### tb/psi_mem_model.sv
/* Data and program memory beside the unit: answers reads at once, logs writes.
   Assumes the unit's strobes are registered on ref_clk. */
`timescale 1ns/10ps
`default_nettype none
module psi_mem_model (
    input wire logic ref_clk,
    input wire logic [11:0] dmem_addr_r,
    input wire logic dmem_rd_r,
    input wire logic dmem_wr_r,
    input wire logic [7:0] dmem_wdata_r,
    input wire logic [14:0] pmem_addr_r,
    input wire logic pmem_rd_r,
    output logic [7:0] dmem_rdata,
    output logic [13:0] pmem_rdata,
    output logic [11:0] last_addr,
    output logic [7:0] last_wdata,
    output logic [7:0] wr_cnt
);
    logic [13:0] noise_r = 14'h0;
    logic [7:0] cnt_r = 8'h0;
    // Outside a read the buses churn, so stale data cannot pass for an answer
    assign dmem_rdata = dmem_rd_r ? dmem_addr_r[7:0] ^ 8'h3c : noise_r[7:0];
    assign pmem_rdata = pmem_rd_r ? {pmem_addr_r[13:8], pmem_addr_r[7:0] ^ 8'ha5} : ~noise_r;
    assign wr_cnt = cnt_r;
    // Log the last access so the bench sees where it went
    always_ff @(posedge ref_clk)
    begin
        noise_r <= noise_r + 14'h1357;
        cnt_r <= cnt_r + {7'h0, dmem_wr_r};
        if (dmem_rd_r || dmem_wr_r)
            last_addr <= dmem_addr_r;
        if (dmem_wr_r)
            last_wdata <= dmem_wdata_r;
    end
endmodule : psi_mem_model
`default_nettype wire

// ### tb/tb.sv
/* Self-checking bench for psi_top: core ops, APB registers, stack limits, indirect access.
   Assumes psi_mem_model stands in for the memories. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import psi_pkg::*;
    typedef struct packed {psi_pc_op_e k; logic [10:0] a; logic [7:0] w; logic [14:0] e;} psi_row_s;
    logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ind_req = 1'b0, pready_r, pslverr_r, fault_reset_r, ind_busy_r, ind_done_r, err;
    logic dmem_rd_r, dmem_wr_r, pmem_rd_r;
    logic [7:0] paddr = 8'h0, w_value = 8'h0, dmem_rdata, dmem_wdata_r, ind_rdata_r;
    logic [7:0] last_wdata, wr_cnt, wc;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] pwdata = 32'h0, prdata_r, rd;
    logic [11:0] dmem_addr_r, last_addr;
    logic [13:0] pmem_rdata;
    logic [14:0] pc_r, pmem_addr_r;
    psi_pc_op_s pc_op = '0;
    psi_ind_req_s ind_cmd = '0;
    int n_errors = 0, checked = 0;
    // Latch stays zero here; the stack unwinds back to where it started
    psi_row_s rows [8] = '{'{PSI_OP_NEXT, 11'h0, 8'h0, 15'h1}, '{PSI_OP_BRA, 11'h1fe, 8'h0, 15'h0},
        '{PSI_OP_BRW, 11'h0, 8'hff, 15'h100}, '{PSI_OP_BRA, 11'h0ff, 8'h0, 15'h200},
        '{PSI_OP_CALL, 11'h7ff, 8'h0, 15'h7ff}, '{PSI_OP_COMPUTED_CALL, 11'h0, 8'h12, 15'h12},
        '{PSI_OP_RETURN, 11'h0, 8'h0, 15'h800}, '{PSI_OP_RETURN, 11'h0, 8'h0, 15'h201}};
    psi_top u_dut (.*);
    psi_mem_model u_mem (.*);
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic bound(input logic ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            test_done();
        end
    endtask : bound
    // One APB transfer; waits for pready with a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (!pready_r && ++i < 9);
        bound(pready_r);
        rd = prdata_r;
        err = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic op(input psi_pc_op_e k, input logic [10:0] a, input logic [7:0] w);
        @(posedge ref_clk);
        pc_op <= '{k, 1'b0, a};
        w_value <= w;
        @(posedge ref_clk);
        pc_op <= '0;
        #1;
    endtask : op
    task automatic setp(input logic s, input logic [15:0] v);
        apb(1'b1, 8'h14 + {s, 3'h0}, {24'h0, v[7:0]});
        apb(1'b1, 8'h18 + {s, 3'h0}, {24'h0, v[15:8]});
    endtask : setp
    task automatic ind(input logic s, input logic w, input logic [7:0] d);
        int i = 0;
        @(posedge ref_clk);
        ind_req <= 1'b1;
        ind_cmd <= '{s, w, d};
        @(posedge ref_clk);
        ind_req <= 1'b0;
        do @(posedge ref_clk); while (!ind_done_r && ++i < 9);
        bound(ind_done_r);
    endtask : ind
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk(32'(pc_r), 32'h0);
        foreach (rows[i])
        begin
            op(rows[i].k, rows[i].a, rows[i].w);
            chk(32'(pc_r), 32'(rows[i].e));
        end
        $display("pc table done");
        apb(1'b1, PSI_OFF_PC_LATCH, 32'h55);
        op(PSI_OP_WRITE_LOW, 11'h34, 8'h0);
        chk(32'(pc_r), 32'h5534);
        op(PSI_OP_CALL, 11'h123, 8'h0);
        chk(32'(pc_r), 32'h5123);
        apb(1'b0, PSI_OFF_PC_LATCH, 32'h0);
        chk(rd, 32'h55);
        apb(1'b0, PSI_OFF_TOS_LOW, 32'h0);
        chk(rd, 32'h35);
        apb(1'b0, PSI_OFF_TOS_HIGH, 32'h0);
        chk(rd, 32'h55);
        // Sixteen more calls run one past the top level
        repeat (16) op(PSI_OP_CALL, 11'h0, 8'h0);
        repeat (3) @(posedge ref_clk);
        #1;
        chk(32'(pc_r), 32'h0);
        apb(1'b0, PSI_OFF_STACK_PTR, 32'h0);
        chk(rd, 32'h1f);
        apb(1'b1, PSI_OFF_CONFIG, 32'h0);
        op(PSI_OP_RETURN, 11'h0, 8'h0);
        apb(1'b0, PSI_OFF_POWER_CTRL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 8'h3c, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Fault reset is off now: a vector push from level sixteen wraps onto entry 0
        apb(1'b1, PSI_OFF_PC_LOW, 32'h77);
        apb(1'b1, PSI_OFF_STACK_PTR, 32'hf);
        @(posedge ref_clk);
        pc_op <= '{PSI_OP_NONE, 1'b1, 11'h0};
        @(posedge ref_clk);
        pc_op <= '0;
        #1;
        chk(32'(pc_r), 32'(PSI_VECTOR_ADDR));
        apb(1'b0, PSI_OFF_STACK_PTR, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, PSI_OFF_TOS_LOW, 32'h0);
        chk(rd, 32'h77);
        $display("stack done");
        setp(1'b0, 16'h2050);
        ind(1'b0, 1'b0, 8'h0);
        chk(32'(ind_rdata_r), 32'h9c);
        chk(32'(last_addr), 32'h0a0);
        setp(1'b1, 16'h1000);
        ind(1'b1, 1'b0, 8'h0);
        chk(32'(ind_rdata_r), 32'h0);
        setp(1'b1, 16'h8123);
        ind(1'b1, 1'b0, 8'h0);
        chk(32'(ind_rdata_r), 32'h86);
        setp(1'b0, 16'h0001);
        ind(1'b0, 1'b0, 8'h0);
        chk(32'(ind_rdata_r), 32'h0);
        wc = wr_cnt;
        ind(1'b0, 1'b1, 8'h22);
        ind(1'b1, 1'b1, 8'h11);
        chk(32'(wr_cnt), 32'(wc));
        setp(1'b0, 16'h0070);
        ind(1'b0, 1'b1, 8'h5e);
        chk(32'({last_addr, last_wdata}), 32'h0705e);
        $display("indirect done");
        test_done();
    end
endmodule : tb
bind psi_top psi_chk u_chk (.*);
`default_nettype wire
